// ---- odet_pkg.sv ----
// odet_pkg: shared constants and types of the orientation detector and its host
// assumes: accel samples are signed 8-bit at 32 counts/g, registers 8 bits wide
package odet_pkg;

  // device register offsets
  localparam logic [7:0]  ODET_ANGLE_OFF      = 8'h5C;
  localparam logic [7:0]  ODET_DEADBAND_OFF   = 8'h5F;
  localparam logic [7:0]  ODET_CTRL_OFF       = 8'h1B;
  localparam logic [7:0]  ODET_QUAL_OFF       = 8'h5E;
  localparam logic [7:0]  ODET_STATE_OFF      = 8'h10;

  // device reset values
  localparam logic [7:0]  ODET_ANGLE_RST      = 8'h0C;
  localparam logic [7:0]  ODET_DEADBAND_RST   = 8'h14;
  localparam logic [7:0]  ODET_CTRL_RST       = 8'h00;
  localparam logic [7:0]  ODET_QUAL_RST       = 8'h00;

  // device field positions
  localparam int          ODET_ENABLE_BIT     = 7;
  localparam int          ODET_BAND_MSB       = 4;
  localparam int          ODET_TRIM_LSB       = 5;

  // classification limits, counts at 32 counts/g
  localparam logic [7:0]  ODET_COUNTS_PER_G   = 8'h20;
  localparam logic [7:0]  ODET_MAJOR_LIM      = 8'h1B;
  localparam logic [7:0]  ODET_MINOR_BASE     = 8'h16;
  localparam logic [7:0]  ODET_MINOR_DEF      = 8'h10;
  localparam logic [7:0]  ODET_BAND_DEF       = 8'h14;
  localparam logic [7:0]  ODET_LOW_SLOPE_NUM  = 8'h03;
  localparam logic [7:0]  ODET_LOW_SLOPE_DEN  = 8'h0A;
  localparam logic [7:0]  ODET_HIGH_SLOPE_NUM = 8'h10;
  localparam logic [7:0]  ODET_HIGH_SLOPE_DEN = 8'h0B;
  localparam logic [7:0]  ODET_MIN_ANGLE_CNT  = 8'h06;

  // host APB register offsets
  localparam logic [11:0] ODET_H_CMD_OFF      = 12'h000;
  localparam logic [11:0] ODET_H_STATUS_OFF   = 12'h004;
  localparam logic [11:0] ODET_H_INT_OFF      = 12'h008;
  localparam logic [11:0] ODET_H_MASK_OFF     = 12'h00C;

  // host field positions
  localparam int          ODET_CMD_WRITE_BIT  = 16;
  localparam int          ODET_CMD_ADDR_LSB   = 8;
  localparam int          ODET_INT_DONE       = 0;
  localparam int          ODET_INT_ORIENT     = 1;
  localparam int          ODET_INT_REFUSED    = 2;
  localparam int          ODET_INT_W          = 3;
  localparam logic [2:0]  ODET_INT_RST        = 3'h0;

  typedef enum logic [2:0] {
    ODET_FACE_UP,
    ODET_FACE_DOWN,
    ODET_ROT_0,
    ODET_ROT_90,
    ODET_ROT_180,
    ODET_ROT_270
  } odet_orient_t;

  typedef enum logic [1:0] {
    ODET_H_IDLE,
    ODET_H_TRIM_RD,
    ODET_H_XFER
  } odet_hstate_t;

endpackage : odet_pkg

// ---- odet_if.sv ----
// odet_if: register port and orientation report between device and host
// assumes: both ends on the same pclk, device answers every request once
`timescale 1ns/10ps
interface odet_if;
  import odet_pkg::*;
  logic               reg_req;
  logic               reg_we;
  logic [7:0]         reg_addr;
  logic [7:0]         reg_wdata;
  logic [7:0]         reg_rdata;
  logic               reg_ack;
  odet_orient_t       orient_state;
  logic               orient_evt;

  modport dev (
    input  reg_req,
    input  reg_we,
    input  reg_addr,
    input  reg_wdata,
    output reg_rdata,
    output reg_ack,
    output orient_state,
    output orient_evt
  );

  modport host (
    output reg_req,
    output reg_we,
    output reg_addr,
    output reg_wdata,
    input  reg_rdata,
    input  reg_ack,
    input  orient_state,
    input  orient_evt
  );
endinterface : odet_if

// ---- odet_host.sv ----
// odet_host: APB-controlled host that configures the orientation detector
// assumes: APB master on pclk, device end of odet_if on the same clock
`timescale 1ns/10ps
module odet_host
  import odet_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  odet_if.host             bus
);

  odet_hstate_t          state_reg;
  logic                  pready_reg;
  logic [31:0]           prdata_reg;
  logic                  req_reg;
  logic                  we_reg;
  logic [7:0]            addr_reg;
  logic [7:0]            wdata_reg;
  logic [7:0]            rdata_reg;
  logic                  enable_shadow_reg;
  logic [ODET_INT_W-1:0] int_reg;
  logic [ODET_INT_W-1:0] int_next;
  logic [ODET_INT_W-1:0] mask_reg;
  logic                  irq_reg;

  wire       apb_done   = psel & penable & pready_reg;
  wire       apb_wr     = apb_done & pwrite;
  wire       apb_rd     = apb_done & ~pwrite;
  wire       cmd_go     = apb_wr & (paddr == ODET_H_CMD_OFF) & (state_reg == ODET_H_IDLE);
  wire [7:0] cmd_addr   = pwdata[ODET_CMD_ADDR_LSB +: 8];
  wire [7:0] cmd_data   = pwdata[7:0];
  wire       cmd_write  = pwdata[ODET_CMD_WRITE_BIT];
  wire       cfg_target = (cmd_addr == ODET_ANGLE_OFF) | (cmd_addr == ODET_DEADBAND_OFF)
                        | (cmd_addr == ODET_QUAL_OFF);
  wire       refuse_run = cmd_write & cfg_target & enable_shadow_reg;
  wire       refuse_ang = cmd_write & (cmd_addr == ODET_ANGLE_OFF)
                        & (cmd_data < ODET_MIN_ANGLE_CNT);
  wire       refuse     = refuse_run | refuse_ang;
  wire       rmw_band   = cmd_write & (cmd_addr == ODET_DEADBAND_OFF);
  wire       xfer_end   = (state_reg == ODET_H_XFER) & bus.reg_ack;
  wire       trim_end   = (state_reg == ODET_H_TRIM_RD) & bus.reg_ack;
  wire       busy       = (state_reg != ODET_H_IDLE);

  wire [31:0] status_word = {13'h0000, bus.orient_state, rdata_reg, 6'h00,
                             enable_shadow_reg, busy};
  wire [31:0] rd_mux =
      (paddr == ODET_H_STATUS_OFF) ? status_word :
      (paddr == ODET_H_INT_OFF)    ? {29'h0, int_reg} :
      (paddr == ODET_H_MASK_OFF)   ? {29'h0, mask_reg} : 32'h0000_0000;

  // sticky events, read clears, a set in the clearing cycle wins
  wire [ODET_INT_W-1:0] int_set = {cmd_go & refuse, bus.orient_evt, xfer_end};
  wire                  int_clr = apb_rd & (paddr == ODET_H_INT_OFF);
  assign int_next = (int_clr ? {ODET_INT_W{1'b0}} : int_reg) | int_set;

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = 1'b0;
  assign irq     = irq_reg;
  assign bus.reg_req   = req_reg;
  assign bus.reg_we    = we_reg;
  assign bus.reg_addr  = addr_reg;
  assign bus.reg_wdata = wdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      int_reg    <= ODET_INT_RST;
      mask_reg   <= ODET_INT_RST;
      irq_reg    <= 1'b0;
    end else if (ce) begin
      pready_reg <= psel & penable & ~pready_reg;
      if (psel & penable & ~pready_reg) begin
        prdata_reg <= rd_mux;
      end
      if (apb_wr & (paddr == ODET_H_MASK_OFF)) begin
        mask_reg <= pwdata[ODET_INT_W-1:0];
      end
      int_reg <= int_next;
      irq_reg <= |(int_next & mask_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg         <= ODET_H_IDLE;
      req_reg           <= 1'b0;
      we_reg            <= 1'b0;
      addr_reg          <= 8'h00;
      wdata_reg         <= 8'h00;
      rdata_reg         <= 8'h00;
      enable_shadow_reg <= 1'b0;
    end else if (ce) begin
      unique case (state_reg)
        ODET_H_IDLE: begin
          if (cmd_go & ~refuse) begin
            req_reg   <= 1'b1;
            addr_reg  <= cmd_addr;
            wdata_reg <= cmd_data;
            we_reg    <= cmd_write & ~rmw_band;
            state_reg <= rmw_band ? ODET_H_TRIM_RD : ODET_H_XFER;
          end
        end
        ODET_H_TRIM_RD: begin
          if (trim_end) begin
            // keep factory trim, replace only the deadband field
            wdata_reg <= {bus.reg_rdata[7:ODET_TRIM_LSB], wdata_reg[ODET_BAND_MSB:0]};
            we_reg    <= 1'b1;
            state_reg <= ODET_H_XFER;
          end
        end
        ODET_H_XFER: begin
          if (xfer_end) begin
            req_reg   <= 1'b0;
            state_reg <= ODET_H_IDLE;
            if (!we_reg) begin
              rdata_reg <= bus.reg_rdata;
            end
            if (we_reg & (addr_reg == ODET_CTRL_OFF)) begin
              enable_shadow_reg <= wdata_reg[ODET_ENABLE_BIT];
            end
          end
        end
      endcase
    end
  end

endmodule : odet_host

// ---- odet_device.sv ----
// odet_device: orientation classifier with tilt threshold, deadband and qualify count
// assumes: one accel sample set per smp_valid pulse, host end of odet_if on pclk
//
// Contract
// - report face-up, face-down and four rotation states
// - eight-bit read-write tilt angle threshold register
// - tilt threshold resets to 0x0C
// - host keeps threshold at or above ten degrees
// - host clears enable before config writes; odet_host refuses them while enabled instead
// - rotation changes only above tilt threshold
// - below threshold, z sign picks face up/down
// - threshold counts are sine times 32
// - default limits 0.866 g major, 0.5 g minor
// - default rotation at 60, return at 30 degrees
// - five-bit deadband field resets to 10100
// - deadband widens hysteresis up to 45 degrees
// - host preserves trim bits when writing deadband
// - eight-bit sample counter qualifies each change
// - one qualify count equals one sample period
`timescale 1ns/10ps
module odet_device
  import odet_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  odet_if.dev              bus,
  input  wire logic        smp_valid,
  input  wire logic [7:0]  ax,
  input  wire logic [7:0]  ay,
  input  wire logic [7:0]  az,
  output odet_orient_t     orient_o,
  output logic             orient_change_o
);

  // configuration registers
  logic [7:0]   ctrl_reg;
  logic [7:0]   angle_reg;
  logic [7:0]   deadband_reg;
  logic [7:0]   qual_reg;

  // register port state
  logic         ack_reg;
  logic [7:0]   rdata_reg;

  // classification state
  odet_orient_t report_reg;
  odet_orient_t pend_reg;
  logic [7:0]   cnt_reg;
  logic         change_reg;

  odet_orient_t cand;
  odet_orient_t rot_cand;
  odet_orient_t report_next;
  odet_orient_t pend_next;
  logic [7:0]   cnt_next;

  // register access decode
  wire take     = bus.reg_req & ~ack_reg;
  wire wr       = take & bus.reg_we;
  wire running  = ctrl_reg[ODET_ENABLE_BIT];
  // config writes ignored while the engine runs
  wire cfg_open = ~running;
  wire wr_ctrl  = wr & (bus.reg_addr == ODET_CTRL_OFF);
  wire wr_angle = wr & cfg_open & (bus.reg_addr == ODET_ANGLE_OFF);
  wire wr_band  = wr & cfg_open & (bus.reg_addr == ODET_DEADBAND_OFF);
  wire wr_qual  = wr & cfg_open & (bus.reg_addr == ODET_QUAL_OFF);

  wire [7:0] rd_mux =
      (bus.reg_addr == ODET_CTRL_OFF)     ? ctrl_reg :
      (bus.reg_addr == ODET_ANGLE_OFF)    ? angle_reg :
      (bus.reg_addr == ODET_DEADBAND_OFF) ? deadband_reg :
      (bus.reg_addr == ODET_QUAL_OFF)     ? qual_reg :
      (bus.reg_addr == ODET_STATE_OFF)    ? {5'h00, report_reg} : 8'h00;

  // magnitudes of the horizontal axes
  wire       ax_neg = ax[7];
  wire       ay_neg = ay[7];
  wire [7:0] ax_mag = ax_neg ? 8'(~ax + 8'h01) : ax;
  wire [7:0] ay_mag = ay_neg ? 8'(~ay + 8'h01) : ay;

  // tilt: horizontal gravity against sine of the threshold angle
  wire [16:0] tilt_sq   = 17'(ax_mag * ax_mag) + 17'(ay_mag * ay_mag);
  wire [16:0] thr_sq    = 17'(angle_reg * angle_reg);
  wire        tilt_ok   = tilt_sq > thr_sq;

  // deadband to minor-axis limit: 16 counts at the default, 0 at full scale
  wire [7:0] band8      = {3'h0, deadband_reg[ODET_BAND_MSB:0]};
  wire [7:0] low_drop   = 8'((band8 * ODET_LOW_SLOPE_NUM) / ODET_LOW_SLOPE_DEN);
  wire [7:0] high_drop  = 8'(((band8 - ODET_BAND_DEF) * ODET_HIGH_SLOPE_NUM)
                          / ODET_HIGH_SLOPE_DEN);
  wire       band_low   = band8 <= ODET_BAND_DEF;
  wire [7:0] minor_lim  = band_low ? 8'(ODET_MINOR_BASE - low_drop)
                                   : 8'(ODET_MINOR_DEF - high_drop);

  wire       ax_minor   = ax_mag < minor_lim;
  wire       ay_minor   = ay_mag < minor_lim;
  wire       ax_major   = ax_mag > ODET_MAJOR_LIM;
  wire       ay_major   = ay_mag > ODET_MAJOR_LIM;

  wire       z_down     = az[7];
  wire       sample_go  = smp_valid & running;

  always_comb begin
    rot_cand = report_reg;
    if (ax_minor & ay_major & ~ay_neg) begin
      rot_cand = ODET_ROT_0;
    end else if (ax_major & ~ax_neg & ay_minor) begin
      rot_cand = ODET_ROT_90;
    end else if (ax_minor & ay_major & ay_neg) begin
      rot_cand = ODET_ROT_180;
    end else if (ax_major & ax_neg & ay_minor) begin
      rot_cand = ODET_ROT_270;
    end
    // in the hysteresis band the reported state stands
  end

  always_comb begin
    if (!tilt_ok) begin
      cand = z_down ? ODET_FACE_DOWN : ODET_FACE_UP;
    end else begin
      cand = rot_cand;
    end
  end

  // qualification: count consecutive samples holding the same new state
  always_comb begin
    report_next = report_reg;
    pend_next   = pend_reg;
    cnt_next    = cnt_reg;
    if (sample_go) begin
      if (cand == report_reg) begin
        pend_next = report_reg;
        cnt_next  = 8'h00;
      end else if (cand != pend_reg) begin
        pend_next = cand;
        cnt_next  = 8'h01;
      end else if (cnt_reg != 8'hFF) begin
        cnt_next  = 8'(cnt_reg + 8'h01);
      end
      if ((cand != report_reg) && (cnt_next >= qual_reg)) begin
        report_next = cand;
        pend_next   = cand;
        cnt_next    = 8'h00;
      end
    end
  end

  assign orient_o         = report_reg;
  assign orient_change_o  = change_reg;
  assign bus.reg_ack      = ack_reg;
  assign bus.reg_rdata    = rdata_reg;
  assign bus.orient_state = report_reg;
  assign bus.orient_evt   = change_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg     <= ODET_CTRL_RST;
      angle_reg    <= ODET_ANGLE_RST;
      deadband_reg <= ODET_DEADBAND_RST;
      qual_reg     <= ODET_QUAL_RST;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_reg <= bus.reg_wdata;
      end
      if (wr_angle) begin
        angle_reg <= bus.reg_wdata;
      end
      if (wr_band) begin
        deadband_reg <= bus.reg_wdata;
      end
      if (wr_qual) begin
        qual_reg <= bus.reg_wdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 8'h00;
    end else if (ce) begin
      ack_reg <= take;
      if (take) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      report_reg <= ODET_FACE_UP;
      pend_reg   <= ODET_FACE_UP;
      cnt_reg    <= 8'h00;
      change_reg <= 1'b0;
    end else if (ce) begin
      report_reg <= report_next;
      pend_reg   <= pend_next;
      cnt_reg    <= cnt_next;
      change_reg <= report_next != report_reg;
    end
  end

endmodule : odet_device

// ---- odet_sva.sv ----
// odet_sva: timing and rule checks on the device-host register link
// assumes: instantiated in tb beside odet_if, ce held high throughout
`timescale 1ns/10ps
module odet_sva
  import odet_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         reg_req,
  input wire logic         reg_we,
  input wire logic [7:0]   reg_addr,
  input wire logic [7:0]   reg_wdata,
  input wire logic [7:0]   reg_rdata,
  input wire logic         reg_ack,
  input odet_orient_t      orient_state,
  input wire logic         orient_evt
);
  logic       taken;
  logic       cfg_wr;
  logic       rd_trim_reg;
  logic [2:0] trim_reg;
  logic       en_reg;
  assign taken  = reg_req && !reg_ack;
  assign cfg_wr = taken && reg_we && (reg_addr == ODET_ANGLE_OFF || reg_addr == ODET_QUAL_OFF ||
                  reg_addr == ODET_DEADBAND_OFF);

  // last taken request was a read of the deadband register, and its trim bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_trim_reg <= 1'b0;
      trim_reg    <= 3'h0;
      en_reg      <= 1'b0;
    end else begin
      if (taken) rd_trim_reg <= !reg_we && (reg_addr == ODET_DEADBAND_OFF);
      if (reg_ack && rd_trim_reg) trim_reg <= reg_rdata[7:5];
      if (taken && reg_we && reg_addr == ODET_CTRL_OFF) en_reg <= reg_wdata[ODET_ENABLE_BIT];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ack_latency; taken |=> reg_ack; endproperty
  a_ack_latency: assert property (p_ack_latency) else $error("ack missing after request");
  property p_ack_pulse; reg_ack |-> ##1 !reg_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_rdata_hold; $changed(reg_rdata) |-> reg_ack; endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without ack");
  property p_req_hold;
    taken |=> reg_req && $stable(reg_we) && $stable(reg_addr) && $stable(reg_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before ack");
  property p_evt_after; $changed(orient_state) |-> orient_evt; endproperty
  a_evt_after: assert property (p_evt_after) else $error("no event after state change");
  property p_evt_cause; orient_evt |-> orient_state != $past(orient_state); endproperty
  a_evt_cause: assert property (p_evt_cause) else $error("event without state change");
  property p_trim_keep;
    taken && reg_we && reg_addr == ODET_DEADBAND_OFF |-> rd_trim_reg && reg_wdata[7:5] == trim_reg;
  endproperty
  a_trim_keep: assert property (p_trim_keep) else $error("deadband write lost trim bits");
  property p_min_angle;
    taken && reg_we && reg_addr == ODET_ANGLE_OFF |-> reg_wdata >= ODET_MIN_ANGLE_CNT;
  endproperty
  a_min_angle: assert property (p_min_angle) else $error("angle below minimum sent");
  property p_cfg_disabled; cfg_wr |-> !en_reg; endproperty
  a_cfg_disabled: assert property (p_cfg_disabled) else $error("config write while enabled");
endmodule : odet_sva

// ---- tb.sv ----
// tb: host over APB configures the device, samples drive orientation changes
// assumes: odet_host and odet_device joined by odet_if on one 25 MHz pclk
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import odet_pkg::*;
  logic         pclk;
  logic         presetn;
  logic         ce;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         irq;
  logic         smp_valid;
  logic [7:0]   ax;
  logic [7:0]   ay;
  logic [7:0]   az;
  odet_orient_t orient_o;
  logic         orient_change_o;
  logic [31:0]  r;
  logic [7:0]   q;
  int           mismatches;
  int           comparisons;

  odet_if odet_if_i ();
  odet_host odet_host_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .bus(odet_if_i));
  odet_device odet_device_i (.pclk(pclk), .presetn(presetn), .ce(ce), .bus(odet_if_i),
    .smp_valid(smp_valid), .ax(ax), .ay(ay), .az(az), .orient_o(orient_o),
    .orient_change_o(orient_change_o));
  odet_sva odet_sva_i (.pclk(pclk), .presetn(presetn), .reg_req(odet_if_i.reg_req),
    .reg_we(odet_if_i.reg_we), .reg_addr(odet_if_i.reg_addr), .reg_wdata(odet_if_i.reg_wdata),
    .reg_rdata(odet_if_i.reg_rdata), .reg_ack(odet_if_i.reg_ack),
    .orient_state(odet_if_i.orient_state), .orient_evt(odet_if_i.orient_evt));

  always #20 pclk = ~pclk;

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one device register access through the command register, polled to idle
  task automatic dev(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] rd);
    logic [31:0] s;
    apb(1'b1, ODET_H_CMD_OFF, {15'h0000, wr, a, d}, s);
    s = 32'h00000001;
    while (s[0] === 1'b1) apb(1'b0, ODET_H_STATUS_OFF, 32'h00000000, s);
    rd = s[15:8];
  endtask : dev

  task automatic smpn(input int n, input logic [7:0] x, input logic [7:0] y,
                      input logic [7:0] z, input odet_orient_t mid, input odet_orient_t last);
    for (int i = 1; i <= n; i++) begin
      @(posedge pclk);
      smp_valid <= 1'b1;
      ax        <= x;
      ay        <= y;
      az        <= z;
      @(posedge pclk);
      smp_valid <= 1'b0;
      #1;
      `CHK(orient_o, (i == n) ? last : mid)
    end
  endtask : smpn

  task automatic test_done;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  initial begin
    pclk = 1'b0; presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h00000000; smp_valid = 1'b0; ax = 8'h00; ay = 8'h00; az = 8'h00;
    mismatches = 0; comparisons = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    dev(1'b0, ODET_ANGLE_OFF, 8'h00, q); `CHK(q, 8'h0C)
    dev(1'b0, ODET_DEADBAND_OFF, 8'h00, q); `CHK(q, 8'h14)
    dev(1'b0, ODET_STATE_OFF, 8'h00, q); `CHK(q, 8'h00)
    dev(1'b0, 8'h33, 8'h00, q); `CHK(q, 8'h00)
    apb(1'b0, ODET_H_INT_OFF, 32'h0, r); `CHK(r, 32'h00000001)
    apb(1'b0, ODET_H_INT_OFF, 32'h0, r); `CHK(r, 32'h00000000)
    apb(1'b0, 12'h010, 32'h0, r); `CHK(pslverr, 1'b0)
    $display("test reset values done");
    dev(1'b1, ODET_ANGLE_OFF, 8'hA5, q); dev(1'b0, ODET_ANGLE_OFF, 8'h00, q); `CHK(q, 8'hA5)
    dev(1'b1, ODET_ANGLE_OFF, 8'h10, q);
    dev(1'b1, ODET_ANGLE_OFF, 8'h05, q);
    apb(1'b0, ODET_H_INT_OFF, 32'h0, r); `CHK(r[2], 1'b1)
    dev(1'b0, ODET_ANGLE_OFF, 8'h00, q); `CHK(q, 8'h10)
    dev(1'b1, ODET_DEADBAND_OFF, 8'h00, q); dev(1'b0, ODET_DEADBAND_OFF, 8'h00, q); `CHK(q, 8'h00)
    $display("test angle and deadband done");
    dev(1'b1, ODET_QUAL_OFF, 8'h03, q); dev(1'b1, ODET_CTRL_OFF, 8'h80, q);
    dev(1'b1, ODET_ANGLE_OFF, 8'h20, q);
    apb(1'b0, ODET_H_INT_OFF, 32'h0, r); `CHK(r[2], 1'b1)
    apb(1'b0, ODET_H_STATUS_OFF, 32'h0, r); `CHK(r[1], 1'b1)
    dev(1'b0, ODET_ANGLE_OFF, 8'h00, q); `CHK(q, 8'h10)
    apb(1'b1, ODET_H_MASK_OFF, 32'h00000002, r);
    apb(1'b0, ODET_H_INT_OFF, 32'h0, r); `CHK(irq, 1'b0)
    $display("test enable refusal done");
    smpn(3, 8'h00, 8'h20, 8'h00, ODET_FACE_UP, ODET_ROT_0);
    `CHK(orient_change_o, 1'b1)
    repeat (4) @(posedge pclk);
    #1; `CHK(irq, 1'b1)
    apb(1'b0, ODET_H_INT_OFF, 32'h0, r); `CHK(r[1], 1'b1)
    repeat (3) @(posedge pclk);
    #1; `CHK(irq, 1'b0)
    smpn(2, 8'h20, 8'h00, 8'h00, ODET_ROT_0, ODET_ROT_0);
    smpn(1, 8'h00, 8'h20, 8'h00, ODET_ROT_0, ODET_ROT_0);
    smpn(3, 8'h20, 8'h00, 8'h00, ODET_ROT_0, ODET_ROT_90);
    smpn(3, 8'h14, 8'h14, 8'h00, ODET_ROT_90, ODET_ROT_90);
    smpn(3, 8'h14, 8'h1E, 8'h00, ODET_ROT_90, ODET_ROT_0);
    smpn(3, 8'hE4, 8'h00, 8'h00, ODET_ROT_0, ODET_ROT_270);
    smpn(3, 8'h00, 8'hE0, 8'h00, ODET_ROT_270, ODET_ROT_180);
    smpn(3, 8'h00, 8'h00, 8'hE0, ODET_ROT_180, ODET_FACE_DOWN);
    smpn(3, 8'h00, 8'h10, 8'h20, ODET_FACE_DOWN, ODET_FACE_UP);
    smpn(3, 8'h00, 8'h1E, 8'h20, ODET_FACE_UP, ODET_ROT_0);
    $display("test orientation states done");
    dev(1'b1, ODET_CTRL_OFF, 8'h00, q);
    smpn(3, 8'h00, 8'h00, 8'hE0, ODET_ROT_0, ODET_ROT_0);
    dev(1'b1, ODET_DEADBAND_OFF, 8'hF4, q); dev(1'b0, ODET_DEADBAND_OFF, 8'h00, q); `CHK(q, 8'h14)
    dev(1'b1, ODET_CTRL_OFF, 8'h80, q);
    smpn(3, 8'h18, 8'h15, 8'h00, ODET_ROT_0, ODET_ROT_0);
    smpn(3, 8'h1C, 8'h0F, 8'h00, ODET_ROT_0, ODET_ROT_90);
    smpn(3, 8'h15, 8'h18, 8'h00, ODET_ROT_90, ODET_ROT_90);
    smpn(3, 8'h0F, 8'h1C, 8'h00, ODET_ROT_90, ODET_ROT_0);
    dev(1'b0, ODET_STATE_OFF, 8'h00, q); `CHK(q, 8'h02)
    $display("test default hysteresis done");
    test_done;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    $display("ERROR t=%0t watchdog expired", $time);
    test_done;
  end
endmodule : tb
